// [spi_csl_pkg.sv]
// Shared constants, field positions and helpers of the select and loopback block
package spi_csl_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [31:0] ADR_MODE   = 32'h40008004;   // Mode and select set-up
   localparam logic [31:0] ADR_STATUS = 32'h40008010;   // Sticky events, read only
   localparam logic [31:0] ADR_IEN    = 32'h40008014;   // Interrupt enable, write only
   localparam logic [31:0] ADR_IDIS   = 32'h40008018;   // serial_irq_disable, write only
   localparam logic [31:0] ADR_IMASK  = 32'h4000801C;   // Interrupt mask, read only
   localparam logic [31:0] ADR_EVCLR  = 32'h40008020;   // Event clear, write only

   // ****************************************************************
   // Mode register fields
   // ****************************************************************
   localparam int          MODE_MASTER_BIT = 0;         // Master mode
   localparam int          MODE_VARSEL_BIT = 1;         // variable_select_mode
   localparam int          MODE_DECODE_BIT = 2;         // select_decoder_en
   localparam int          MODE_LOOP_BIT   = 7;         // local_loopback_en
   localparam int          MODE_PCS_LSB    = 16;        // periph_select_field
   localparam int          MODE_GAP_LSB    = 24;        // inter_select_gap
   localparam logic [31:0] MODE_RESET      = 32'h00000000;
   localparam logic [31:0] MODE_WMASK      = 32'hFF0F0087;

   // ****************************************************************
   // Event bits, shared by status, enable, disable and clear
   // ****************************************************************
   localparam int          EV_NUM              = 11;
   localparam int          EV_RX_FULL          = 0;
   localparam int          EV_TX_EMPTY         = 1;
   localparam int          EV_MODE_FAULT       = 2;
   localparam int          EV_OVERRUN          = 3;
   localparam int          EV_RX_BUFFER_END    = 4;
   localparam int          EV_TX_BUFFER_END    = 5;
   localparam int          EV_RX_BUFFERS_FULL  = 6;
   localparam int          EV_TX_BUFFERS_EMPTY = 7;
   localparam int          EV_SLAVE_SEL_RISE   = 8;
   localparam int          EV_TX_IDLE          = 9;
   localparam int          EV_UNDERRUN         = 10;
   localparam logic [10:0] EV_RESET            = 11'h000;

   // ****************************************************************
   // Select timing and codes
   // ****************************************************************
   localparam logic [7:0]  GAP_MIN_CYC = 8'h06;         // Floor of the select gap
   localparam logic [3:0]  CS_NONE     = 4'hF;          // All selects released

   // Gap in clock cycles, with the floor applied
   function automatic logic [7:0] gap_need(input logic [7:0] field);
      gap_need = (field < GAP_MIN_CYC) ? GAP_MIN_CYC : field;
   endfunction

   // Select outputs for a code, direct or one-of-four on the lowest zero
   function automatic logic [3:0] sel_decode(input logic [3:0] code, input logic dec_en);
      if (dec_en)
         sel_decode = code;
      else if (!code[0])
         sel_decode = 4'hE;
      else if (!code[1])
         sel_decode = 4'hD;
      else if (!code[2])
         sel_decode = 4'hB;
      else if (!code[3])
         sel_decode = 4'h7;
      else
         sel_decode = CS_NONE;
   endfunction

endpackage

// [gap_if.sv]
// Handshake between the select sequencer and its gap timer
`timescale 1ns/10ps
interface gap_if;
   logic       load;    // Start a gap
   logic [7:0] count;   // Cycles to run, less one
   logic       done;    // Timer idle
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// [pin_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync (
   // Clocking
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Data
   input  wire logic d,
   output logic      q
);

   logic s1_r;   // First stage, read only by the second
   logic s2_r;   // Second stage
   logic s3_r;   // Third stage

   // Shift in; the output follows once two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q    <= 1'b0;
      end else if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q <= s3_r;
         end
      end
   end

endmodule // pin_sync

// [gap_timer.sv]
// Down counter that times the released-select gap
`timescale 1ns/10ps
module gap_timer (
   // Clocking
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Sequencer side
   gap_if.tmr        g
);

   logic [7:0] cnt_r;   // Cycles left

   // Idle when the count has run out
   assign g.done = (cnt_r == 8'h00);

   // Load on request, otherwise count down to zero
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
      end else if (ce) begin
         if (g.load) begin
            cnt_r <= g.count;
         end else if (!g.done) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end

endmodule // gap_timer

// [spi_chip_select_loopback_irq.sv]
// Select encoding, select gap, loopback path and interrupt registers
`timescale 1ns/10ps

// Behaviour
// - Master loopback feeds sent bit to receiver
// - Loopback only in master, off when clear
// - Select field used only in fixed mode
// - No decoder: lowest zero picks one select
// - Decoder on: field drives selects unchanged
// - Wait a gap between release and select
// - Gap is field cycles, minimum six
// - Disable write: ones disable, zeros keep
// - Lower disable bits map the eight events
// - Upper disable bits 8-10, rest unused
module spi_chip_select_loopback_irq (
   // Clock, reset and freeze
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   // Register port
   input  wire logic [31:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // Shift engine side
   input  wire logic [10:0] EVENTS,
   input  wire logic        CS_ACTIVE,
   input  wire logic [3:0]  SEL_VAR,
   input  wire logic        MOSI_BIT,
   output logic             RX_BIT,
   output logic             RX_STROBE,
   // Pins
   input  wire logic        SCK_PIN,
   input  wire logic        MISO_PIN,
   output logic      [3:0]  CHIP_SELECT_N,
   output logic             IRQ
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic sck_s;        // Filtered link clock level
   logic miso_s;       // Filtered receive pin
   logic sck_prev_r;   // Last link clock level
   logic sck_rise_w;   // Rising link clock edge

   pin_sync sck_sync (
      .clk (REF_CLK),
      .rst (RST),
      .ce  (CE),
      .d   (SCK_PIN),
      .q   (sck_s)
   );

   pin_sync miso_sync (
      .clk (REF_CLK),
      .rst (RST),
      .ce  (CE),
      .d   (MISO_PIN),
      .q   (miso_s)
   );

   // Edge found on the filtered level only
   assign sck_rise_w = sck_s & ~sck_prev_r;

   // ****************************************************************
   // Register decode
   // ****************************************************************
   logic wr_mode_w;    // Mode write
   logic wr_ien_w;     // Enable write
   logic wr_idis_w;    // Disable write
   logic wr_evclr_w;   // Clear write

   assign wr_mode_w  = WR && (ADDR == spi_csl_pkg::ADR_MODE);
   assign wr_ien_w   = WR && (ADDR == spi_csl_pkg::ADR_IEN);
   assign wr_idis_w  = WR && (ADDR == spi_csl_pkg::ADR_IDIS);
   assign wr_evclr_w = WR && (ADDR == spi_csl_pkg::ADR_EVCLR);

   // ****************************************************************
   // Mode register and its fields
   // ****************************************************************
   logic [31:0] mode_r;     // Mode register
   logic        master_w;   // Master mode
   logic        varsel_w;   // Variable select mode
   logic        decode_w;   // External decoder
   logic        lb_w;       // Loopback in force
   logic [3:0]  pcs_w;      // Fixed select field
   logic [7:0]  gap_w;      // Gap field

   assign master_w = mode_r[spi_csl_pkg::MODE_MASTER_BIT];
   assign varsel_w = mode_r[spi_csl_pkg::MODE_VARSEL_BIT];
   assign decode_w = mode_r[spi_csl_pkg::MODE_DECODE_BIT];
   assign pcs_w    = mode_r[spi_csl_pkg::MODE_PCS_LSB +: 4];
   assign gap_w    = mode_r[spi_csl_pkg::MODE_GAP_LSB +: 8];
   assign lb_w     = master_w & mode_r[spi_csl_pkg::MODE_LOOP_BIT];

   // Unused bits are kept at zero so a read shows only live fields
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mode_r <= spi_csl_pkg::MODE_RESET;
      end else if (CE && wr_mode_w) begin
         mode_r <= WDATA & spi_csl_pkg::MODE_WMASK;
      end
   end

   // ****************************************************************
   // Events, mask and interrupt
   // ****************************************************************
   logic [10:0] status_r;     // Sticky event flags
   logic [10:0] mask_r;       // Enabled sources
   logic [10:0] status_nxt;   // Next flags
   logic [10:0] mask_nxt;     // Next mask
   logic        irq_r;        // Interrupt level
   logic        pend_w;       // Enabled flag present

   // event k sets flag k; set beats clear
   assign status_nxt = (status_r & ~({11{wr_evclr_w}} & WDATA[10:0])) | EVENTS;
   assign mask_nxt   = (mask_r | ({11{wr_ien_w}} & WDATA[10:0]))
                       & ~({11{wr_idis_w}} & WDATA[10:0]);
   // only enabled flags raise the line
   assign pend_w     = |(status_r & mask_r);

   // Flags, mask and the registered interrupt
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         status_r <= spi_csl_pkg::EV_RESET;
         mask_r   <= spi_csl_pkg::EV_RESET;
         irq_r    <= 1'b0;
      end else if (CE) begin
         status_r <= status_nxt;
         mask_r   <= mask_nxt;
         irq_r    <= pend_w;
      end
   end

   assign IRQ = irq_r;

   // ****************************************************************
   // Read port
   // ****************************************************************
   logic [31:0] rd_mux_w;   // Selected read value
   logic [31:0] rdata_r;    // Read data, one cycle after the strobe

   // Write-only and unmapped addresses read as zero
   assign rd_mux_w = (ADDR == spi_csl_pkg::ADR_MODE)   ? mode_r :
                     (ADDR == spi_csl_pkg::ADR_STATUS) ? {21'h000000, status_r} :
                     (ADDR == spi_csl_pkg::ADR_IMASK)  ? {21'h000000, mask_r} :
                     32'h00000000;

   // Data stands only in the cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rdata_r <= 32'h00000000;
      end else if (CE) begin
         rdata_r <= RD ? rd_mux_w : 32'h00000000;
      end
   end

   assign RDATA = rdata_r;

   // ****************************************************************
   // Select sequencer
   // ****************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_GAP} sel_st_e;

   sel_st_e    st_r;     // Sequencer state
   sel_st_e    st_nxt;   // Next state
   logic [3:0] cs_r;     // Select outputs
   logic [3:0] cs_nxt;   // Next select outputs
   logic [3:0] code_w;   // Select code in force
   logic [3:0] dec_w;    // Decoded select outputs
   logic [7:0] need_w;   // Gap length in cycles
   gap_if      gt ();    // Gap timer link

   // fixed field only while variable mode is off
   assign code_w   = varsel_w ? SEL_VAR : pcs_w;
   // one low select; field passed straight
   assign dec_w    = spi_csl_pkg::sel_decode(code_w, decode_w);
   assign need_w   = spi_csl_pkg::gap_need(gap_w);
   assign gt.count = need_w - 8'h01;

   gap_timer gap_tmr (
      .clk (REF_CLK),
      .rst (RST),
      .ce  (CE),
      .g   (gt)
   );

   // A new code always passes through a release and a full gap
   always_comb begin
      st_nxt  = st_r;
      cs_nxt  = cs_r;
      gt.load = 1'b0;
      case (st_r)
         // Released; select when asked in master mode
         ST_IDLE: begin
            if (CS_ACTIVE && master_w) begin
               st_nxt = ST_SEL;
               cs_nxt = dec_w;
            end
         end
         // release before any change of select
         ST_SEL: begin
            if (!CS_ACTIVE || !master_w || (dec_w != cs_r)) begin
               st_nxt  = ST_GAP;
               cs_nxt  = spi_csl_pkg::CS_NONE;
               gt.load = 1'b1;
            end
         end
         // Hold all released until the timer runs out
         ST_GAP: begin
            if (gt.done) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            cs_nxt = spi_csl_pkg::CS_NONE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st_r <= ST_IDLE;
         cs_r <= spi_csl_pkg::CS_NONE;
      end else if (CE) begin
         st_r <= st_nxt;
         cs_r <= cs_nxt;
      end
   end

   assign CHIP_SELECT_N = cs_r;

   // ****************************************************************
   // Receive path
   // ****************************************************************
   logic rx_bit_r;   // Received bit
   logic rx_stb_r;   // One-cycle bit strobe

   // sent bit replaces the pin in loopback
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sck_prev_r <= 1'b0;
         rx_bit_r   <= 1'b0;
         rx_stb_r   <= 1'b0;
      end else if (CE) begin
         sck_prev_r <= sck_s;
         rx_stb_r   <= sck_rise_w;
         if (sck_rise_w) begin
            rx_bit_r <= lb_w ? MOSI_BIT : miso_s;
         end
      end
   end

   assign RX_BIT    = rx_bit_r;
   assign RX_STROBE = rx_stb_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [7:0] gcnt_r;   // Cycles spent in the gap so far

   // Helper counter for the gap length check
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         gcnt_r <= 8'h00;
      end else if (CE) begin
         gcnt_r <= (st_r == ST_GAP) ? gcnt_r + 8'h01 : 8'h00;
      end
   end

   loop_path_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && sck_rise_w && lb_w |=> RX_BIT == $past(MOSI_BIT) && RX_STROBE)
      else $error("loopback bit not taken from sent data");

   loop_off_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && sck_rise_w && !(master_w && mode_r[spi_csl_pkg::MODE_LOOP_BIT])
      |=> RX_BIT == $past(miso_s))
      else $error("receive bit not taken from pin");

   fixed_field_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && st_r == ST_IDLE && CS_ACTIVE && master_w && !varsel_w
      |=> CHIP_SELECT_N == spi_csl_pkg::sel_decode($past(pcs_w), $past(decode_w)))
      else $error("fixed select field not applied");

   one_low_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && st_r == ST_IDLE && CS_ACTIVE && master_w && !decode_w && code_w != 4'hF
      |=> $countones(~CHIP_SELECT_N) == 1 && !CHIP_SELECT_N[0] == !$past(code_w[0]))
      else $error("undecoded select not one low");

   direct_code_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && st_r == ST_IDLE && CS_ACTIVE && master_w && decode_w
      |=> CHIP_SELECT_N == $past(code_w))
      else $error("decoded select not passed directly");

   release_gap_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && st_r == ST_SEL && st_nxt == ST_GAP
      |=> CHIP_SELECT_N == 4'hF ##1 (CHIP_SELECT_N == 4'hF) [*5])
      else $error("select reasserted inside gap");

   gap_len_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && st_r == ST_GAP && gt.done |-> gcnt_r + 8'h01 == need_w)
      else $error("gap length differs from field");

   disable_bits_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && wr_idis_w |=> (mask_r & $past(WDATA[10:0])) == 11'h000
      && (mask_r & ~$past(WDATA[10:0])) == ($past(mask_r) & ~$past(WDATA[10:0])))
      else $error("disable write misapplied");

   event_map_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && EVENTS != 11'h000 |=> (status_r & $past(EVENTS)) == $past(EVENTS))
      else $error("event flag not set");

   upper_zero_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE && RD && ADDR == spi_csl_pkg::ADR_IMASK |=> RDATA[31:11] == 21'h000000)
      else $error("unused mask bits read nonzero");

   irq_level_a: assert property (
      @(posedge REF_CLK) disable iff (RST)
      CE |=> IRQ == $past(|(status_r & mask_r)))
      else $error("interrupt level wrong");

endmodule // spi_chip_select_loopback_irq

// [serial_periph_model.sv]
// Behavioural model of the serial peripherals that sit on the select lines
`timescale 1ns/10ps
module serial_periph_model (
   // Select side
   input  wire logic [3:0] chip_select_n,
   input  wire logic       force_sel,
   // Link pins
   output logic            sck,
   output logic            miso
);
   // ****************************************************************
   // Frame detect and data source
   // ****************************************************************
   logic [7:0] pattern_r;   // Bits shifted out, rotating
   wire        sel_any;     // Some peripheral is addressed

   // An outside master may address us in slave tests
   assign sel_any = force_sel | ~(&chip_select_n);

   // Link clock runs only inside frames, 125 ns period; data moves on the
   // falling edge so it is steady long before the sampling rise. A released
   // line keeps flipping, so a stale bit can never pass for a valid one.
   initial begin
      sck       = 1'b0;
      miso      = 1'b0;
      pattern_r = 8'hA5;
      forever begin
         if (sel_any) begin
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
            miso      = pattern_r[7];
            pattern_r = {pattern_r[6:0], pattern_r[7]};
         end else begin
            #5 miso = ~miso;
         end
      end
   end
endmodule // serial_periph_model

// [test_spi_chip_select_loopback_irq.sv]
// Self-checking testbench of the select, loopback and interrupt block
`timescale 1ns/10ps
module test_spi_chip_select_loopback_irq;
   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic        REF_CLK, RST, CE, WR, RD, CS_ACTIVE, MOSI_BIT, RX_BIT, RX_STROBE;
   logic        IRQ, force_sel, sck_w, miso_w;
   logic [31:0] ADDR, WDATA, RDATA;
   logic [10:0] EVENTS;
   logic [3:0]  SEL_VAR, CHIP_SELECT_N;
   int          mismatches, comparisons, n, need;
   // Select table rows: decoder bit, field, expected selects
   logic [8:0]  rows [7] = '{9'h0EE, 9'h05D, 9'h03B, 9'h077, 9'h04E, 9'h1AA, 9'h166};
   logic [7:0]  gaps [4] = '{8'h03, 8'h06, 8'h09, 8'h00};   // Gap fields tried

   spi_chip_select_loopback_irq dut_u (
      .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .EVENTS(EVENTS), .CS_ACTIVE(CS_ACTIVE),
      .SEL_VAR(SEL_VAR), .MOSI_BIT(MOSI_BIT), .RX_BIT(RX_BIT), .RX_STROBE(RX_STROBE),
      .SCK_PIN(sck_w), .MISO_PIN(miso_w), .CHIP_SELECT_N(CHIP_SELECT_N), .IRQ(IRQ));

   serial_periph_model periph_u (
      .chip_select_n(CHIP_SELECT_N), .force_sel(force_sel), .sck(sck_w), .miso(miso_w));

   // ****************************************************************
   // Helper tasks
   // ****************************************************************
   // Compare and count; unknowns never match
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      WR <= 1'b1; ADDR <= a; WDATA <= d;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask

   // Read data only stand in the cycle after the strobe
   task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
      @(posedge REF_CLK);
      RD <= 1'b1; ADDR <= a;
      @(posedge REF_CLK);
      RD <= 1'b0;
      @(negedge REF_CLK);
      chk(what, RDATA, exp);
   endtask

   // Mode word: master, variable, decoder, loopback, field, gap
   function automatic logic [31:0] mode(input logic m, v, d, l, input logic [3:0] f,
                                        input logic [7:0] g);
      mode = {g, 4'h0, f, 8'h00, l, 4'h0, d, v, m};
   endfunction

   // Eight received bits; loopback expects our own sent bit
   task automatic rx_bits(input logic loop_on);
      for (int i = 0; i < 8; i++) begin
         n = 0;
         do @(negedge REF_CLK); while (RX_STROBE !== 1'b1 && ++n < 400);
         // A strobe that never came counts as a mismatch, not a stale pass
         chk("rx_strobe", {31'h0, RX_STROBE}, 32'h00000001);
         chk("rx_bit", {31'h0, RX_BIT}, {31'h0, loop_on ? MOSI_BIT : miso_w});
         @(posedge REF_CLK);
         MOSI_BIT <= ~MOSI_BIT;
      end
   endtask

   // Verdict and end of run
   task automatic print_verdict;
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Clock and watchdog
   // ****************************************************************
   initial begin
      REF_CLK = 1'b0;
      forever #2 REF_CLK = ~REF_CLK;
   end

   // Whole run is about a thousand cycles; this span is far beyond it
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      RST = 1'b1; CE = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = '0; WDATA = '0;
      EVENTS = '0; CS_ACTIVE = 1'b0; SEL_VAR = 4'hF; MOSI_BIT = 1'b0; force_sel = 1'b0;
      mismatches = 0; comparisons = 0;
      repeat (6) @(posedge REF_CLK);
      RST <= 1'b0;
      @(negedge REF_CLK);
      chk("sel_reset", {28'h0, CHIP_SELECT_N}, 32'h0000000F);
      chk("irq_reset", {31'h0, IRQ}, 32'h00000000);
      // Fixed selection through the table; field 1111 undecoded never used
      // software side
      foreach (rows[i]) begin
         wr(spi_csl_pkg::ADR_MODE, mode(1'b1, 1'b0, rows[i][8], 1'b0, rows[i][7:4], 8'h00));
         CS_ACTIVE <= 1'b1;
         repeat (3) @(posedge REF_CLK);
         @(negedge REF_CLK);
         chk("sel_table", {28'h0, CHIP_SELECT_N}, {28'h0, rows[i][3:0]});
         @(posedge REF_CLK);
         CS_ACTIVE <= 1'b0;
         repeat (10) @(posedge REF_CLK);
      end
      // Variable mode: code comes from the engine, gap then floors at six
      foreach (gaps[i]) begin
         wr(spi_csl_pkg::ADR_MODE, mode(1'b1, 1'b1, 1'b0, 1'b0, 4'h7, gaps[i]));
         SEL_VAR <= 4'hE;
         CS_ACTIVE <= 1'b1;
         repeat (3) @(posedge REF_CLK);
         @(negedge REF_CLK);
         chk("sel_var", {28'h0, CHIP_SELECT_N}, 32'h0000000E);
         @(posedge REF_CLK);
         SEL_VAR <= 4'hD;
         n = 0;
         do @(negedge REF_CLK); while (CHIP_SELECT_N !== 4'hF && ++n < 10);
         n = 0;
         while (CHIP_SELECT_N === 4'hF && n < 300) begin
            n++;
            @(negedge REF_CLK);
         end
         need = (gaps[i] < 8'h06) ? 6 : int'(gaps[i]);
         chk("gap_cycles", n, need + 1);
         chk("sel_after", {28'h0, CHIP_SELECT_N}, 32'h0000000D);
         @(posedge REF_CLK);
         CS_ACTIVE <= 1'b0;
         repeat (12) @(posedge REF_CLK);
      end
      // Each event: raise, mask with a single disable bit, clear
      for (int k = 0; k < 11; k++) begin
         wr(spi_csl_pkg::ADR_IEN, 32'h000007FF);
         // Sample once the full mask has reached the interrupt register
         repeat (2) @(negedge REF_CLK);
         chk("irq_idle", {31'h0, IRQ}, 32'h00000000);
         @(posedge REF_CLK);
         EVENTS <= 11'h001 << k;
         @(posedge REF_CLK);
         EVENTS <= 11'h000;
         @(posedge REF_CLK);
         @(negedge REF_CLK);
         chk("irq_set", {31'h0, IRQ}, 32'h00000001);
         // Upper unused bits written as ones must do nothing
         wr(spi_csl_pkg::ADR_IDIS, 32'hFFFFF800 | (32'h1 << k));
         rd("mask", spi_csl_pkg::ADR_IMASK, 32'h000007FF ^ (32'h1 << k));
         chk("irq_masked", {31'h0, IRQ}, 32'h00000000);
         rd("status", spi_csl_pkg::ADR_STATUS, 32'h1 << k);
         wr(spi_csl_pkg::ADR_EVCLR, 32'h000007FF);
      end
      // Event and clear in one cycle: the event must survive
      @(posedge REF_CLK);
      EVENTS <= 11'h004;
      WR     <= 1'b1;
      ADDR   <= spi_csl_pkg::ADR_EVCLR;
      WDATA  <= 32'h000007FF;
      @(posedge REF_CLK);
      EVENTS <= 11'h000;
      WR     <= 1'b0;
      rd("set_wins", spi_csl_pkg::ADR_STATUS, 32'h00000004);
      wr(spi_csl_pkg::ADR_EVCLR, 32'h000007FF);
      // Reads of unmapped and write-only places give zero
      rd("unmapped", 32'h40008000, 32'h00000000);
      rd("idis_read", spi_csl_pkg::ADR_IDIS, 32'h00000000);
      wr(spi_csl_pkg::ADR_MODE, 32'hFFFFFFFF);
      rd("mode_rw", spi_csl_pkg::ADR_MODE, spi_csl_pkg::MODE_WMASK);
      // Clock enable low: a write must not land
      @(posedge REF_CLK);
      CE <= 1'b0;
      wr(spi_csl_pkg::ADR_MODE, 32'h00000000);
      CE <= 1'b1;
      rd("mode_frozen", spi_csl_pkg::ADR_MODE, spi_csl_pkg::MODE_WMASK);
      // Loopback in master mode: receiver sees what we send
      wr(spi_csl_pkg::ADR_MODE, mode(1'b1, 1'b0, 1'b0, 1'b1, 4'hE, 8'h00));
      CS_ACTIVE <= 1'b1;
      rx_bits(1'b1);
      CS_ACTIVE <= 1'b0;
      repeat (40) @(posedge REF_CLK);
      // Slave mode: loopback bit ignored, no select driven, pin data received
      wr(spi_csl_pkg::ADR_MODE, mode(1'b0, 1'b0, 1'b0, 1'b1, 4'hE, 8'h00));
      CS_ACTIVE <= 1'b1;
      force_sel <= 1'b1;
      rx_bits(1'b0);
      chk("sel_slave", {28'h0, CHIP_SELECT_N}, 32'h0000000F);
      force_sel <= 1'b0;
      // Reset in mid-run with a select held
      wr(spi_csl_pkg::ADR_MODE, mode(1'b1, 1'b0, 1'b0, 1'b0, 4'hE, 8'h00));
      repeat (40) @(posedge REF_CLK);
      RST <= 1'b1;
      @(posedge REF_CLK);
      RST <= 1'b0;
      CS_ACTIVE <= 1'b0;
      @(negedge REF_CLK);
      chk("sel_rst", {28'h0, CHIP_SELECT_N}, 32'h0000000F);
      rd("mode_rst", spi_csl_pkg::ADR_MODE, 32'h00000000);
      print_verdict();
   end
endmodule // test_spi_chip_select_loopback_irq
